// ### core/ersr_regs.sv
`timescale 1ns/10ps
// What this block does
// R1: Search counter adds one each time an 8 ms CRC4 search expires.
// R2: Search counter clears when CRC4 multiframe sync is achieved.
// R3: Search counter held clear while CRC4 framing enable bit is zero.
// R4: Search counter is six bits, wraps, sits in synchronizer status bits 7..3; the code shows counter bits 5..2 and 0 there, not bit 1.
// R5: Host should abandon CRC4 search after 400 ms, timed by the counter.
// R6: Signaling all ones flag set on fewer than three zeros per multiframe.
// R7: Signaling all zeros flag set when slot 16 is all zeros.
// R8: Signaling change sets both all ones and all zeros flags.
// R9: Distant multiframe alarm set after two consecutive multiframes with bit set.
// R10: Signaling all ones and distant alarm stay active in CCS mode.
// R11: Receive slip flag set on each frame repeat or delete.
// R12: Unframed all ones flag set on all ones on recovered data.
// R13: Remote alarm flag set on received remote alarm indication.
// R14: Carrier loss optionally detected on digital recovered data inputs.
// R15: Loss of sync flag set while framer is not synchronized.
// R16: Flags latch until read; read clears; only new events set again.
// R17: Condition flags stay set after read while condition persists.
// R18: Synchronizer status is read only, live, no mask write needed.
// R19: Carrier loss after 255 or 2048 zeros; clears on 32 ones in 255.
// R20: Information register latches store full/empty and jitter limit events.
// R21: Information register latches CRC, FAS and CAS resync criteria events.
// R22: Synchronizer status shows FAS, CAS and CRC4 search active live.
module ersr_regs
  import ersr_pkg::*;
#(
  parameter logic [11:0] ZERO_RUN_SHORT = CL_ZEROS_SHORT,  // Zeros that declare carrier loss
  parameter logic [11:0] ZERO_RUN_LONG  = CL_ZEROS_LONG,   // Same, with the long option chosen
  parameter logic [7:0]  WINDOW_BITS    = CL_WINDOW_BITS,  // Bits in one release window
  parameter logic [7:0]  ONES_TO_CLEAR  = CL_ONES_CLEAR    // Marks in a window that release the alarm
)
(
  input  wire logic           i_clock,
  input  wire logic           i_resetn,
  input  wire logic           i_bit_enable,       // One pulse per received bit
  input  wire logic           i_line_mark,        // Analog receiver saw a one
  input  wire logic           i_rx_positive_data_in,
  input  wire logic           i_rx_negative_data_in,
  input  wire logic           i_carrier_digital,  // Use recovered data for carrier loss
  input  wire logic           i_carrier_long,     // 2048 zero threshold
  input  wire logic           i_crc_framing_enable_bit,
  input  wire ersr_alarm_in_t i_alarm,
  input  wire ersr_info_in_t  i_info,
  input  wire ersr_sync_in_t  i_sync,
  input  wire logic [7:0]     i_addr,
  input  wire logic [7:0]     i_wdata,
  input  wire logic           i_write,
  input  wire logic           i_read,
  output logic [7:0]          o_rdata,
  output logic                o_carrier_loss
);

  ////////////////////////////////////////////////////////////////////////////
  // Carrier loss detector

  logic [11:0] zero_run;
  logic [7:0]  win_count;
  logic [7:0]  ones_count;
  logic        mark;
  logic [11:0] zero_limit;

  // Thresholds that the counters below cannot honour are refused before anything runs
  if (ZERO_RUN_SHORT == 12'h000 || ZERO_RUN_LONG == 12'h000 || WINDOW_BITS < 8'h02 ||
      ONES_TO_CLEAR == 8'h00 || ONES_TO_CLEAR > WINDOW_BITS) begin : g_bad_carrier
    $error("carrier loss thresholds out of range");
  end

  // Digital option looks at either rail of the recovered data
  assign mark       = i_carrier_digital ? (i_rx_positive_data_in | i_rx_negative_data_in)
                                        : i_line_mark;  // R14
  assign zero_limit = i_carrier_long ? ZERO_RUN_LONG : ZERO_RUN_SHORT;  // R19

  // Declare on a zero run, release on enough ones inside a window
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      zero_run       <= 12'h000;
      win_count      <= 8'h00;
      ones_count     <= 8'h00;
      o_carrier_loss <= 1'b0;
    end else if (i_bit_enable) begin
      // Saturate rather than wrap, so a switch to the short limit mid-run still declares
      zero_run <= mark ? 12'h000 : ((zero_run >= zero_limit) ? zero_run : zero_run + 12'h001);
      if (!o_carrier_loss) begin
        win_count  <= 8'h00;
        ones_count <= 8'h00;
        if (!mark && (zero_run + 12'h001 >= zero_limit))
          o_carrier_loss <= 1'b1;  // R19
      end else if (win_count == WINDOW_BITS - 8'h01) begin
        // Window closes: a short count restarts rather than sliding, simpler and still bounded
        if (ones_count + {7'h00, mark} >= ONES_TO_CLEAR)
          o_carrier_loss <= 1'b0;  // R19
        win_count  <= 8'h00;
        ones_count <= 8'h00;
      end else begin
        win_count  <= win_count + 8'h01;
        ones_count <= ones_count + {7'h00, mark};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched registers

  logic [7:0] alarm_status;
  logic [7:0] info_status;
  logic [7:0] alarm_set;
  logic [7:0] alarm_cond;
  logic [7:0] info_set;
  logic       rd_alarm;
  logic       rd_info;

  // Bit order: all ones, distant MF, all zeros, slip, unframed ones, remote, carrier, sync
  assign alarm_set = {i_alarm.sig_all_ones | i_alarm.sig_change,   // R6 R8 R10
                      i_alarm.distant_mf_alarm,                    // R9 R10
                      i_alarm.sig_all_zeros | i_alarm.sig_change,  // R7 R8
                      i_alarm.rx_slip,                             // R11
                      i_alarm.unframed_all_ones,                   // R12
                      i_alarm.remote_alarm,                        // R13
                      o_carrier_loss,
                      i_alarm.loss_of_sync};                       // R15
  // Conditions that must survive a read while still present
  assign alarm_cond = {i_alarm.sig_all_ones, i_alarm.distant_mf_alarm, i_alarm.sig_all_zeros,
                       1'b0, i_alarm.unframed_all_ones, i_alarm.remote_alarm,
                       o_carrier_loss, i_alarm.loss_of_sync};
  assign info_set   = i_info;  // R20 R21
  assign rd_alarm   = i_read && (i_addr == ADDR_RX_ALARM_STATUS);
  assign rd_info    = i_read && (i_addr == ADDR_RX_INFORMATION);

  // Alarm register: a read keeps the conditions still present and drops the events
  ersr_flag_bank #(
    .WIDTH ($bits(alarm_set))
  ) u_alarm_bank (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_clear  (rd_alarm),    // R16
    .i_set    (alarm_set),
    .i_keep   (alarm_cond),  // R17
    .o_flags  (alarm_status)
  );

  // Information register: every bit is an event, so nothing survives a read
  ersr_flag_bank #(
    .WIDTH ($bits(info_set))
  ) u_info_bank (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_clear  (rd_info),     // R16
    .i_set    (info_set),    // R20 R21
    .i_keep   (FLAGS_RESET),
    .o_flags  (info_status)
  );

  ////////////////////////////////////////////////////////////////////////////
  // CRC4 sync search counter

  logic [SEARCH_COUNT_W-1:0] search_count;

  // One step is one failed search, so the host reads elapsed search time from it;
  // it wraps silently, so a host that polls too rarely will misjudge a long search

  // Clear wins over a timeout in the same cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn)
      search_count <= SEARCH_COUNT_ZERO;
    else if (!i_crc_framing_enable_bit)
      search_count <= SEARCH_COUNT_ZERO;                  // R3
    else if (i_sync.crc_mf_locked)
      search_count <= SEARCH_COUNT_ZERO;                  // R2
    else if (i_sync.crc_mf_timeout)
      search_count <= search_count + SEARCH_COUNT_ONE;    // R1 R4
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; bit 1 of the counter is not visible (five bits shown)
  // Writes are ignored: the live register needs no mask write, and the mask scheme of
  // the latched registers is left out, so a read clears every flag of the register read except conditions still present

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn)
      o_rdata <= 8'h00;
    else if (i_read) begin
      case (i_addr)
        ADDR_RX_ALARM_STATUS: o_rdata <= alarm_status;
        ADDR_RX_INFORMATION:  o_rdata <= info_status;
        ADDR_SYNC_STATUS:     o_rdata <= {search_count[5:2], search_count[0],    // R4 R18
                                          i_sync.fas_search, i_sync.cas_search,
                                          i_sync.crc_search};                     // R22
        default:              o_rdata <= 8'h00;
      endcase
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// One register of read-to-clear flags. A set in the cycle of the read wins, so an
// event that lands while the host is reading is held for the next read, not lost.
module ersr_flag_bank
  import ersr_pkg::*;
#(
  parameter int unsigned WIDTH = $bits(FLAGS_RESET)  // Flags in the register
)
(
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire logic             i_clear,  // Host read of this register
  input  wire logic [WIDTH-1:0] i_set,    // Events and live conditions this cycle
  input  wire logic [WIDTH-1:0] i_keep,   // Conditions that must survive the read
  output logic      [WIDTH-1:0] o_flags
);

  // The reset value is one register wide; any other width has no defined reset
  if (WIDTH != $bits(FLAGS_RESET)) begin : g_bad_width
    $error("flag register width must match the register reset value");
  end

  // Set wins over the read clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn)
      o_flags <= FLAGS_RESET;
    else
      o_flags <= (i_clear ? i_keep : o_flags) | i_set;  // R16 R17
  end

endmodule

// ### core/ersr_pkg.sv
package ersr_pkg;

  // Register addresses on the parallel port
  localparam logic [7:0] ADDR_RX_ALARM_STATUS = 8'h06;
  localparam logic [7:0] ADDR_RX_INFORMATION  = 8'h08;
  localparam logic [7:0] ADDR_SYNC_STATUS     = 8'h1e;

  // Latched register reset value
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Search counter geometry
  localparam int          SEARCH_COUNT_W    = 6;
  localparam logic [5:0]  SEARCH_COUNT_ZERO = 6'h00;
  localparam logic [5:0]  SEARCH_COUNT_ONE  = 6'h01;

  // Carrier loss thresholds in bit times
  localparam logic [11:0] CL_ZEROS_SHORT = 12'hff;
  localparam logic [11:0] CL_ZEROS_LONG  = 12'h800;
  localparam logic [7:0]  CL_WINDOW_BITS = 8'hff;
  localparam logic [7:0]  CL_ONES_CLEAR  = 8'h20;

  // Events and conditions from the framer for the alarm status register
  typedef struct packed {
    logic sig_all_ones;     // condition
    logic distant_mf_alarm; // condition
    logic sig_all_zeros;    // condition
    logic sig_change;       // event
    logic rx_slip;          // event
    logic unframed_all_ones;// condition
    logic remote_alarm;     // condition
    logic loss_of_sync;     // condition
  } ersr_alarm_in_t;

  // Events for the receive information register
  typedef struct packed {
    logic tx_store_full;
    logic tx_store_empty;
    logic jitter_limit;
    logic rx_store_full;
    logic rx_store_empty;
    logic crc_resync;
    logic fas_resync;
    logic cas_resync;
  } ersr_info_in_t;

  // Live synchronizer state
  typedef struct packed {
    logic crc_mf_timeout;   // one 8 ms search expired
    logic crc_mf_locked;    // CRC4 multiframe sync reached
    logic fas_search;
    logic cas_search;
    logic crc_search;
  } ersr_sync_in_t;

endpackage

// ### test/ersr_regs_monitor.sv
`timescale 1ns/10ps
module ersr_regs_monitor
  import ersr_pkg::*;
(
  input wire logic           i_clock,
  input wire logic           i_resetn,
  input wire logic           i_bit_enable,
  input wire logic           i_crc_framing_enable_bit,
  input wire ersr_alarm_in_t i_alarm,
  input wire ersr_info_in_t  i_info,
  input wire ersr_sync_in_t  i_sync,
  input wire logic [7:0]     i_addr,
  input wire logic           i_read,
  input wire logic [7:0]     o_rdata,
  input wire logic           o_carrier_loss
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////
  // Read steps
  sequence s_rd(logic [7:0] a); i_read && i_addr == a; endsequence
  sequence s_quiet; i_read && i_addr == ADDR_RX_ALARM_STATUS && i_alarm == 8'h00; endsequence
  // Events are looked at two edges back, with no read between that could clear them
  chk_sync_live_bits: assert property (s_rd(ADDR_SYNC_STATUS) |=>
    o_rdata[2:0] == $past({i_sync.fas_search, i_sync.cas_search, i_sync.crc_search}))
    else $error("search flags not live");
  chk_count_held_clear: assert property (s_rd(ADDR_SYNC_STATUS) ##0
    !i_crc_framing_enable_bit && $past(!i_crc_framing_enable_bit) |=> o_rdata[7:3] == 5'h00)
    else $error("count not held");
  chk_count_lock_clear: assert property (s_rd(ADDR_SYNC_STATUS) ##0 $past(i_sync.crc_mf_locked, 2) &&
    !$past(i_sync.crc_mf_timeout) |=> o_rdata[7:3] == 5'h00) else $error("count not cleared by lock");
  chk_change_sets_both: assert property (s_rd(ADDR_RX_ALARM_STATUS) ##0 $past(i_alarm.sig_change, 2) &&
    !$past(i_read) |=> o_rdata[7] && o_rdata[5]) else $error("signaling change lost");
  chk_slip_latched: assert property (s_rd(ADDR_RX_ALARM_STATUS) ##0 $past(i_alarm.rx_slip, 2) &&
    !$past(i_read) |=> o_rdata[4]) else $error("slip lost");
  chk_los_persists: assert property (s_rd(ADDR_RX_ALARM_STATUS) ##0 $past(i_alarm.loss_of_sync) |=>
    o_rdata[0]) else $error("loss of sync dropped");
  chk_info_store_full: assert property (s_rd(ADDR_RX_INFORMATION) ##0 $past(i_info.tx_store_full, 2) &&
    !$past(i_read) |=> o_rdata[7]) else $error("store full lost");
  chk_read_clears: assert property (s_quiet ##1 i_alarm == 8'h00 ##1 s_quiet |=>
    (o_rdata & 8'hfd) == 8'h00) else $error("flags not cleared by read");
  chk_carrier_on_bit: assert property ($rose(o_carrier_loss) |-> $past(i_bit_enable))
    else $error("carrier loss off bit time");
endmodule
bind ersr_regs ersr_regs_monitor u_mon (.i_clock, .i_resetn, .i_bit_enable, .i_crc_framing_enable_bit,
  .i_alarm, .i_info, .i_sync, .i_addr, .i_read, .o_rdata, .o_carrier_loss);

// ### test/ersr_regs_test.sv
`timescale 1ns/10ps
module ersr_regs_test
  import ersr_pkg::*;
  ;
  logic           i_clock = 1'b0, i_resetn = 1'b0, i_bit_enable = 1'b0, i_line_mark = 1'b0;
  logic           i_rx_positive_data_in = 1'b0, i_rx_negative_data_in = 1'b0, i_carrier_digital = 1'b0;
  logic           i_carrier_long = 1'b0, i_crc_framing_enable_bit = 1'b0, i_write = 1'b0, i_read = 1'b0;
  ersr_alarm_in_t i_alarm = 8'h00;
  ersr_info_in_t  i_info = 8'h00;
  ersr_sync_in_t  i_sync = 5'h00;
  logic [7:0]     i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic           o_carrier_loss;
  int             num_errors = 0, samples_checked = 0, k;
  // Framer inputs and the register bits they land in differ in order
  logic [7:0]     ain [8] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h02, 8'h01, 8'h10, 8'h08};
  logic [7:0]     aex [8] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h01, 8'ha0, 8'h10};
  ersr_regs dut (.i_clock, .i_resetn, .i_bit_enable, .i_line_mark, .i_rx_positive_data_in,
    .i_rx_negative_data_in, .i_carrier_digital, .i_carrier_long, .i_crc_framing_enable_bit, .i_alarm,
    .i_info, .i_sync, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata, .o_carrier_loss);
  // 20 MHz clock
  always #25 i_clock = ~i_clock;
  ////////////////////////////////
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic exp);
    samples_checked++;
    if (o_carrier_loss !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, o_carrier_loss, exp);
    end
  endtask
  // Read data is sampled just after the edge that loads it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock) i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock) i_read <= 1'b0;
    #1 chk(exp, o_rdata);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clock) i_sync.crc_mf_timeout <= 1'b1;
      @(posedge i_clock) i_sync.crc_mf_timeout <= 1'b0;
    end
  endtask
  // Analog mark and a recovered rail are set apart so the chosen source shows
  task automatic bits(input int n, input logic lm, input logic rp);
    repeat (n) begin
      @(posedge i_clock) i_bit_enable <= 1'b1;
      i_line_mark <= lm;
      i_rx_negative_data_in <= rp;
      @(posedge i_clock) i_bit_enable <= 1'b0;
    end
    #1;
  endtask
  function automatic logic [7:0] sx(input logic [5:0] c);
    return {c[5:2], c[0], 3'h5};
  endfunction
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    give_verdict;
  end
  ////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock) i_write <= 1'b1;
    i_wdata <= 8'hff;
    i_addr <= ADDR_SYNC_STATUS;
    @(posedge i_clock) i_write <= 1'b0;
    rd(ADDR_SYNC_STATUS, 8'h00);
    rd(ADDR_RX_ALARM_STATUS, FLAGS_RESET);
    rd(8'h07, 8'h00);
    for (k = 0; k < 8; k++) begin
      @(posedge i_clock) i_info <= 8'h01 << k;
      @(posedge i_clock) i_info <= 8'h00;
      rd(ADDR_RX_INFORMATION, 8'h01 << k);
      rd(ADDR_RX_INFORMATION, 8'h00);
    end
    for (k = 0; k < 8; k++) begin
      @(posedge i_clock) i_alarm <= ain[k];
      @(posedge i_clock) if (k > 5) i_alarm <= 8'h00;
      rd(ADDR_RX_ALARM_STATUS, aex[k]);
      rd(ADDR_RX_ALARM_STATUS, k > 5 ? 8'h00 : aex[k]);
      @(posedge i_clock) i_alarm <= 8'h00;
      rd(ADDR_RX_ALARM_STATUS, k > 5 ? 8'h00 : aex[k]);
      rd(ADDR_RX_ALARM_STATUS, 8'h00);
    end
    @(posedge i_clock) i_crc_framing_enable_bit <= 1'b1;
    i_sync.fas_search <= 1'b1;
    i_sync.crc_search <= 1'b1;
    tick(63);
    rd(ADDR_SYNC_STATUS, sx(6'h3f));
    tick(6);
    rd(ADDR_SYNC_STATUS, sx(6'h05));
    @(posedge i_clock) i_sync.crc_mf_locked <= 1'b1;
    @(posedge i_clock) i_sync.crc_mf_locked <= 1'b0;
    rd(ADDR_SYNC_STATUS, sx(6'h00));
    // Fifty expired searches mark the point at which the host gives up
    tick(50);
    rd(ADDR_SYNC_STATUS, sx(6'h32));
    tick(3);
    @(posedge i_clock) i_crc_framing_enable_bit <= 1'b0;
    tick(2);
    rd(ADDR_SYNC_STATUS, sx(6'h00));
    bits(254, 1'b0, 1'b1);
    chk_pin(1'b0);
    bits(1, 1'b0, 1'b1);
    chk_pin(1'b1);
    rd(ADDR_RX_ALARM_STATUS, 8'h02);
    // The release window is 255 bits: one short of it the alarm must still stand
    bits(254, 1'b1, 1'b0);
    chk_pin(1'b1);
    bits(1, 1'b1, 1'b0);
    chk_pin(1'b0);
    rd(ADDR_RX_ALARM_STATUS, 8'h02);
    @(posedge i_clock) i_carrier_digital <= 1'b1;
    i_carrier_long <= 1'b1;
    bits(2047, 1'b1, 1'b0);
    chk_pin(1'b0);
    bits(1, 1'b1, 1'b0);
    chk_pin(1'b1);
    bits(254, 1'b0, 1'b1);
    chk_pin(1'b1);
    bits(1, 1'b0, 1'b1);
    chk_pin(1'b0);
    give_verdict;
  end
endmodule
